// ==== cmt_core.sv ====
// cmt_core: coordinate calculation, taught-colour matching and self-trigger
// assumes samples come from logic on ref_clk; configuration ports held static
//
// Overview of operation
// RL1: x equals red over channel sum, times 4095.
// RL2: y equals green over channel sum, times 4095.
// RL3: intensity equals channel sum divided by three.
// RL4: s equals 5000 times cube-root difference red minus green, plus 5000.
// RL5: i equals 2000 times cube-root difference green minus blue, plus 2000.
// RL6: lightness equals 1160 times cube root of green over 4096.
// RL7: planar modes need colour distance below the chroma radius.
// RL8: planar modes need intensity within taught value plus or minus tolerance.
// RL9: spatial modes need 3D distance below the sphere radius.
// RL10: outside continuous mode every trigger event pulses the trigger indicator.
// RL11: continuous mode updates the result on every sample.
// RL12: self mode starts an interval when the free row stops matching.
// RL13: on return to free, report the colour seen most often.
// RL14: on leaving free, present row 0 on the outputs.
// RL15: on return, present error or longest colour so output always changes.
// RL16: with groups enabled, count and report groups instead of rows; continuous mode reports the matched row.
// RL17: any member of group 0 counts as the free state.
// RL18: after each interval emit averages of coordinates and distance, excluding free.
// RL19: error is colour 255: no match or intensity below lower limit.
// RL20: channels are 12-bit unsigned; zero sum gives zero chromaticity.
// RL21: ties resolve to the lowest-numbered row or group.
`timescale 1ns/100ps
module cmt_core
    import cmt_pkg::*;
(
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire cmt_rgb_t sample,
    input wire cmt_calc_t calc_mode,
    input wire cmt_trigger_indicator_t trigger_indicator_mode,
    input wire logic group_enable,
    input wire logic [15:0] chroma_tolerance_radius,
    input wire logic [15:0] lab_chroma_tolerance_radius,
    input wire logic [15:0] intensity_tolerance,
    input wire logic [15:0] lightness_tolerance,
    input wire logic [15:0] sphere_radius,
    input wire logic [15:0] intensity_lower_limit,
    input wire cmt_coord_t taught [CMT_ROWS],
    input wire logic [4:0] taught_group [CMT_ROWS],
    output logic [7:0] colour_no,
    output logic result_valid,
    output logic trigger_indicator,
    output cmt_avg_t avg,
    output logic avg_valid
);
    function automatic logic [10:0] cmt_cbrt(input logic [11:0] x);
        logic [10:0] res;
        logic [10:0] t;
        logic [33:0] tgt;
        res = 11'h000;
        tgt = 34'(x) << CMT_CBRT_PRESHIFT;
        for (int i = 10; i >= 0; i--) begin
            t = res | (11'h001 << i);
            if (34'(t) * 34'(t) * 34'(t) <= tgt) begin
                res = t;
            end
        end
        return res;
    endfunction : cmt_cbrt
    function automatic logic [16:0] cmt_isqrt(input logic [33:0] x);
        logic [16:0] res;
        logic [16:0] t;
        res = 17'h00000;
        for (int i = 16; i >= 0; i--) begin
            t = res | (17'h00001 << i);
            if (34'(t) * 34'(t) <= x) begin
                res = t;
            end
        end
        return res;
    endfunction : cmt_isqrt
    function automatic logic [31:0] cmt_sqd(input logic [15:0] a, input logic [15:0] b);
        logic [15:0] d;
        d = (a > b) ? a - b : b - a;
        return 32'(d) * 32'(d);
    endfunction : cmt_sqd
    // stage a: coordinates
    logic [13:0] s_sum;
    logic [10:0] cr, cg, cb;
    cmt_coord_t a_d, a_q;
    logic [15:0] ai_d, ai_q;
    logic av_q;
    always_comb begin
        s_sum = 14'(sample.r) + 14'(sample.g) + 14'(sample.b);
        cr = cmt_cbrt(sample.r);
        cg = cmt_cbrt(sample.g);
        cb = cmt_cbrt(sample.b);
        ai_d = 16'(s_sum / 14'(CMT_INT_DIV)); // [RL3]
        a_d = a_q;
        if (sample.valid) begin
            if (calc_mode[0]) begin
                // offset folded in before the shift keeps the math unsigned
                a_d.c0 = 16'((32'(CMT_A_GAIN) * (32'(CMT_CBRT_ONE) + 32'(cr) - 32'(cg))) >> CMT_CBRT_FRAC); // [RL4]
                a_d.c1 = 16'((32'(CMT_B_GAIN) * (32'(CMT_CBRT_ONE) + 32'(cg) - 32'(cb))) >> CMT_CBRT_FRAC); // [RL5]
                a_d.c2 = 16'((32'(CMT_L_GAIN) * 32'(cg)) >> CMT_CBRT_FRAC); // [RL6]
            end else if (s_sum == 14'h0000) begin
                a_d.c0 = 16'h0000; // [RL20]
                a_d.c1 = 16'h0000;
                a_d.c2 = ai_d;
            end else begin
                a_d.c0 = 16'((24'(sample.r) * 24'(CMT_CHROMA_SCALE)) / 24'(s_sum)); // [RL1]
                a_d.c1 = 16'((24'(sample.g) * 24'(CMT_CHROMA_SCALE)) / 24'(s_sum)); // [RL2]
                a_d.c2 = ai_d;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            a_q <= '0;
            ai_q <= 16'h0000;
            av_q <= 1'b0;
        end else begin
            a_q <= a_d;
            ai_q <= sample.valid ? ai_d : ai_q;
            av_q <= sample.valid;
        end
    end

    // stage b: matching against every taught row
    logic [CMT_ROWS-1:0] hit;
    logic [33:0] dsq [CMT_ROWS];
    logic [15:0] rad2d, tol2d;
    assign rad2d = calc_mode[0] ? lab_chroma_tolerance_radius : chroma_tolerance_radius;
    assign tol2d = calc_mode[0] ? lightness_tolerance : intensity_tolerance;
    genvar k;
    generate
        for (k = 0; k < CMT_ROWS; k++) begin : g_row
            logic [32:0] pl;
            logic [31:0] ht;
            always_comb begin
                pl = 33'(cmt_sqd(a_q.c0, taught[k].c0)) + 33'(cmt_sqd(a_q.c1, taught[k].c1));
                ht = cmt_sqd(a_q.c2, taught[k].c2);
                if (calc_mode[1]) begin
                    dsq[k] = 34'(pl) + 34'(ht);
                    hit[k] = dsq[k] < 34'(32'(sphere_radius) * 32'(sphere_radius)); // [RL9]
                end else begin
                    dsq[k] = 34'(pl);
                    // squared comparison avoids a square root per row
                    hit[k] = (pl < 33'(32'(rad2d) * 32'(rad2d))) // [RL7]
                        && (ht <= 32'(tol2d) * 32'(tol2d)); // [RL8]
                end
            end
        end
    endgenerate
    logic [4:0] m_row, m_cls;
    logic m_hit, m_free;
    logic [7:0] m_colour;
    logic [15:0] m_dc;
    always_comb begin
        m_row = 5'h00;
        m_hit = 1'b0;
        for (int i = CMT_ROWS - 1; i >= 0; i--) begin
            if (hit[i]) begin
                m_row = 5'(i);
                m_hit = 1'b1;
            end
        end
        m_colour = (m_hit && ai_q >= intensity_lower_limit) ? {3'h0, m_row} : CMT_ERR_CODE; // [RL19]
        m_dc = 16'(cmt_isqrt(dsq[m_row]));
        m_cls = group_enable ? taught_group[m_row] : m_row; // [RL16]
        m_free = (m_colour != CMT_ERR_CODE) && (m_cls == 5'h00); // [RL12] [RL17]
    end

    // trigger and reporting
    cmt_state_t st_d, st_q;
    logic [15:0] cnt_d [CMT_CLASSES], cnt_q [CMT_CLASSES];
    logic [31:0] sum_d [4], sum_q [4];
    logic [15:0] tot_d, tot_q;
    logic [7:0] col_d, col_q;
    logic rv_d, rv_q, ti_d, ti_q, avv_d, avv_q;
    cmt_avg_t avg_d, avg_q;
    logic clr, acc;
    logic [4:0] best;
    logic [15:0] bc;
    always_comb begin
        st_d = st_q;
        cnt_d = cnt_q;
        sum_d = sum_q;
        tot_d = tot_q;
        col_d = col_q;
        avg_d = avg_q;
        rv_d = 1'b0;
        ti_d = 1'b0;
        avv_d = 1'b0;
        clr = 1'b0;
        acc = 1'b0;
        best = 5'h00;
        bc = 16'h0000;
        for (int i = 0; i < CMT_CLASSES; i++) begin
            if (cnt_q[i] > bc) begin // [RL21]
                bc = cnt_q[i];
                best = 5'(i);
            end
        end
        case (trigger_indicator_mode)
            CMT_TRIGGER_INDICATOR_CONTINUOUS_TRIGGER_MODE: begin
                st_d = CMT_ST_FREE;
                if (av_q) begin
                    col_d = m_colour; // [RL11]
                    rv_d = 1'b1;
                end
            end
            default: begin
                case (st_q)
                    CMT_ST_FREE: begin
                        if (av_q && !m_free) begin
                            st_d = CMT_ST_BUSY; // [RL12]
                            col_d = 8'h00; // [RL14]
                            rv_d = 1'b1;
                            ti_d = 1'b1; // [RL10]
                            clr = 1'b1;
                            acc = 1'b1;
                        end
                    end
                    default: begin
                        if (av_q && m_free) begin
                            st_d = CMT_ST_FREE;
                            col_d = (bc == 16'h0000) ? CMT_ERR_CODE : {3'h0, best}; // [RL13] [RL15]
                            rv_d = 1'b1;
                            ti_d = 1'b1; // [RL10]
                            avv_d = 1'b1;
                            if (tot_q != 16'h0000) begin
                                avg_d.coord.c0 = 16'(sum_q[0] / 32'(tot_q)); // [RL18]
                                avg_d.coord.c1 = 16'(sum_q[1] / 32'(tot_q));
                                avg_d.coord.c2 = 16'(sum_q[2] / 32'(tot_q));
                                avg_d.delta_c = 16'(sum_q[3] / 32'(tot_q));
                            end else begin
                                avg_d = '0;
                            end
                        end else if (av_q) begin
                            acc = 1'b1;
                        end
                    end
                endcase
            end
        endcase
        if (clr) begin
            for (int i = 0; i < CMT_CLASSES; i++) begin
                cnt_d[i] = 16'h0000;
            end
            for (int j = 0; j < 4; j++) begin
                sum_d[j] = 32'h00000000;
            end
            tot_d = 16'h0000;
        end
        // free hits never reach here, so averages exclude them
        if (acc && m_colour != CMT_ERR_CODE && tot_d != CMT_CNT_MAX) begin
            cnt_d[m_cls] = cnt_d[m_cls] + 16'h0001; // [RL16]
            sum_d[0] = sum_d[0] + 32'(a_q.c0); // [RL18]
            sum_d[1] = sum_d[1] + 32'(a_q.c1);
            sum_d[2] = sum_d[2] + 32'(a_q.c2);
            sum_d[3] = sum_d[3] + 32'(m_dc);
            tot_d = tot_d + 16'h0001;
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            st_q <= CMT_ST_FREE;
            cnt_q <= '{default: 16'h0000};
            sum_q <= '{default: 32'h00000000};
            tot_q <= 16'h0000;
            col_q <= CMT_ERR_CODE;
            avg_q <= '0;
            rv_q <= 1'b0;
            ti_q <= 1'b0;
            avv_q <= 1'b0;
        end else begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            sum_q <= sum_d;
            tot_q <= tot_d;
            col_q <= col_d;
            avg_q <= avg_d;
            rv_q <= rv_d;
            ti_q <= ti_d;
            avv_q <= avv_d;
        end
    end

    assign colour_no = col_q;
    assign result_valid = rv_q;
    assign trigger_indicator = ti_q;
    assign avg = avg_q;
    assign avg_valid = avv_q;
    default clocking cb_clk @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    sequence s_leave;
        st_q == CMT_ST_FREE ##1 st_q == CMT_ST_BUSY;
    endsequence
    sequence s_return;
        st_q == CMT_ST_BUSY ##1 st_q == CMT_ST_FREE && trigger_indicator_mode == CMT_TRIGGER_INDICATOR_SELF;
    endsequence
    property p_x;
        sample.valid && calc_mode == CMT_XYI_2D && s_sum != 14'h0000 |=>
            32'(a_q.c0) * 32'($past(s_sum)) <= 32'($past(sample.r)) * 32'(CMT_CHROMA_SCALE);
    endproperty
    a_x: assert property (p_x) else $error("x coordinate too large"); // [RL1]
    property p_y;
        sample.valid && calc_mode == CMT_XYI_2D && s_sum != 14'h0000 |=>
            32'($past(sample.g)) * 32'(CMT_CHROMA_SCALE) < 32'(a_q.c1 + 16'h0001) * 32'($past(s_sum));
    endproperty
    a_y: assert property (p_y) else $error("y coordinate too small"); // [RL2]
    property p_int;
        sample.valid && calc_mode == CMT_XYI_3D |=>
            18'(a_q.c2) * 18'h00003 <= 18'($past(s_sum)) && 18'($past(s_sum)) < 18'(a_q.c2) * 18'h00003 + 18'h00003;
    endproperty
    a_int: assert property (p_int) else $error("intensity not sum over three"); // [RL3]
    property p_zero;
        sample.valid && !calc_mode[0] && s_sum == 14'h0000 |=> a_q.c0 == 16'h0000 && a_q.c1 == 16'h0000;
    endproperty
    a_zero: assert property (p_zero) else $error("zero sum gave nonzero chromaticity"); // [RL20]
    property p_continuous_trigger_mode;
        trigger_indicator_mode == CMT_TRIGGER_INDICATOR_CONTINUOUS_TRIGGER_MODE && av_q |=> result_valid && colour_no == $past(m_colour) && !trigger_indicator;
    endproperty
    a_continuous_trigger_mode: assert property (p_continuous_trigger_mode) else $error("continuous result not updated"); // [RL11]
    property p_leave;
        s_leave |-> trigger_indicator && colour_no == 8'h00 && result_valid;
    endproperty
    a_leave: assert property (p_leave) else $error("leaving free did not present row 0"); // [RL14]
    property p_return;
        s_return |-> trigger_indicator && avg_valid ##1 !avg_valid;
    endproperty
    a_return: assert property (p_return) else $error("return lacks trigger or single average"); // [RL18]
    property p_change;
        s_return |-> colour_no != 8'h00;
    endproperty
    a_change: assert property (p_change) else $error("self trigger did not change output"); // [RL15]
    property p_low;
        av_q && ai_q < intensity_lower_limit && trigger_indicator_mode == CMT_TRIGGER_INDICATOR_CONTINUOUS_TRIGGER_MODE |=> colour_no == CMT_ERR_CODE;
    endproperty
    a_low: assert property (p_low) else $error("low intensity not reported as error"); // [RL19]
endmodule : cmt_core

// ==== cmt_pkg.sv ====
// cmt_pkg: constants, modes and carriers of the colour match and trigger core
// assumes 12-bit unsigned channel readings and one 25 MHz clock domain
package cmt_pkg;
    localparam int CMT_ROWS = 31;
    localparam int CMT_CLASSES = 32;
    localparam int CMT_CH_W = 12;
    localparam int CMT_CO_W = 16;
    localparam logic [7:0] CMT_ERR_CODE = 8'hFF;
    localparam logic [11:0] CMT_CHROMA_SCALE = 12'hFFF;
    localparam logic [1:0] CMT_INT_DIV = 2'h3;
    localparam logic [15:0] CMT_A_GAIN = 16'h1388;
    localparam logic [15:0] CMT_B_GAIN = 16'h07D0;
    localparam logic [15:0] CMT_L_GAIN = 16'h0488;
    // cube roots are held scaled by 1024, so 1024 stands for a root of one
    localparam logic [11:0] CMT_CBRT_ONE = 12'h400;
    localparam int CMT_CBRT_FRAC = 10;
    localparam int CMT_CBRT_PRESHIFT = 18;
    localparam logic [15:0] CMT_CNT_MAX = 16'hFFFF;

    typedef enum logic [1:0] {
        CMT_XYI_2D = 2'b00,
        CMT_LAB_2D = 2'b01,
        CMT_XYI_3D = 2'b10,
        CMT_LAB_3D = 2'b11
    } cmt_calc_t;

    typedef enum logic {
        CMT_TRIGGER_INDICATOR_CONTINUOUS_TRIGGER_MODE = 1'b0,
        CMT_TRIGGER_INDICATOR_SELF = 1'b1
    } cmt_trigger_indicator_t;

    typedef enum logic {
        CMT_ST_FREE = 1'b0,
        CMT_ST_BUSY = 1'b1
    } cmt_state_t;

    typedef struct packed {
        logic valid;
        logic [CMT_CH_W-1:0] r;
        logic [CMT_CH_W-1:0] g;
        logic [CMT_CH_W-1:0] b;
    } cmt_rgb_t;

    // c0/c1/c2 are x/y/intensity or s/i/lightness depending on mode
    typedef struct packed {
        logic [CMT_CO_W-1:0] c0;
        logic [CMT_CO_W-1:0] c1;
        logic [CMT_CO_W-1:0] c2;
    } cmt_coord_t;

    typedef struct packed {
        cmt_coord_t coord;
        logic [CMT_CO_W-1:0] delta_c;
    } cmt_avg_t;
endpackage : cmt_pkg

// ==== cmt_rgb_src.sv ====
// cmt_rgb_src: stand-in for the digitised photodetector channels feeding the core
// assumes the bench calls send and idle from one process, clocked by ref_clk
`timescale 1ns/100ps
module cmt_rgb_src
    import cmt_pkg::*;
(
    input wire logic ref_clk,
    output cmt_rgb_t sample
);
    initial sample = '0;

    // values change just after the edge and hold until the next edge takes them
    task automatic send(input int r, input int g, input int b);
        @(posedge ref_clk);
        sample.valid <= 1'b1;
        sample.r <= CMT_CH_W'(r);
        sample.g <= CMT_CH_W'(g);
        sample.b <= CMT_CH_W'(b);
    endtask : send

    // released channels toggle every cycle so stale data can never look valid
    task automatic idle(input int n);
        repeat (n) begin
            @(posedge ref_clk);
            sample.valid <= 1'b0;
            sample.r <= ~sample.r;
            sample.g <= ~sample.g;
            sample.b <= ~sample.b;
        end
    endtask : idle
endmodule : cmt_rgb_src

// ==== color_match_trigger_logic_tb.sv ====
// color_match_trigger_logic_tb: self-checking bench of cmt_core against an integer model
// assumes cmt_rgb_src drives the samples; configuration changes only while idle
`timescale 1ns/100ps
module color_match_trigger_logic_tb;
    import cmt_pkg::*;
    logic ref_clk = 1'b0;
    logic reset_n = 1'b0;
    cmt_rgb_t sample;
    cmt_calc_t calc_mode = CMT_XYI_3D;
    cmt_trigger_indicator_t trigger_indicator_mode = CMT_TRIGGER_INDICATOR_CONTINUOUS_TRIGGER_MODE;
    logic group_enable = 1'b0;
    logic [15:0] chroma_rad = 16'h00C8, lab_rad = 16'h00C8, int_tol = 16'h0064, light_tol = 16'h0064;
    logic [15:0] sph_rad = 16'h00C8, low_lim = 16'h0032;
    cmt_coord_t taught [CMT_ROWS];
    logic [4:0] taught_group [CMT_ROWS];
    logic [7:0] colour_no;
    logic result_valid, trigger_indicator, avg_valid;
    cmt_avg_t avg;
    int bad_count = 0;
    int n_compared = 0;
    int tx [CMT_ROWS], ty [CMT_ROWS], ti [CMT_ROWS], grp [CMT_ROWS];
    int br [5] = '{2000, 500, 800, 600, 1500};
    int bg [5] = '{1000, 2000, 800, 1500, 1500};
    int bb [5] = '{1000, 500, 2400, 900, 1000};
    int seq_rows [14] = '{1, 2, 2, -1, 1, 2, 0, 3, 1, 0, -1, 0, 4, 0};
    int seq_grps [12] = '{2, 2, 2, 1, 1, 3, 3, 4, 0, 4, 1, 0};
    longint q_t [$], q_at [$];
    int q_c [$], q_tr [$];
    logic [63:0] q_a [$];
    int cnt [CMT_CLASSES];
    int busy = 0, n_hit, sx, sy, si, sd, mn;

    always #20 ref_clk = ~ref_clk;

    cmt_rgb_src src_u (.ref_clk(ref_clk), .sample(sample));

    cmt_core dut_u (.ref_clk(ref_clk), .reset_n(reset_n), .sample(sample), .calc_mode(calc_mode),
        .trigger_indicator_mode(trigger_indicator_mode), .group_enable(group_enable), .chroma_tolerance_radius(chroma_rad),
        .lab_chroma_tolerance_radius(lab_rad), .intensity_tolerance(int_tol),
        .lightness_tolerance(light_tol), .sphere_radius(sph_rad), .intensity_lower_limit(low_lim),
        .taught(taught), .taught_group(taught_group), .colour_no(colour_no),
        .result_valid(result_valid), .trigger_indicator(trigger_indicator), .avg(avg),
        .avg_valid(avg_valid));

    task automatic summarize();
        if (bad_count == 0 && n_compared > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : summarize

    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask : chk

    function automatic void coords(input int r, input int g, input int b, output int x, output int y,
        output int i, output int m);
        int s;
        s = r + g + b;
        m = s / 3;
        x = (s != 0) ? r * 4095 / s : 0;
        y = (s != 0) ? g * 4095 / s : 0;
        i = m;
        if (calc_mode[0]) begin
            // roots scaled by 1024, offsets folded in before the divide
            x = 5000 * (1024 + cbrt(r) - cbrt(g)) / 1024;
            y = 2000 * (1024 + cbrt(g) - cbrt(b)) / 1024;
            i = 1160 * cbrt(g) / 1024;
        end
    endfunction : coords

    function automatic int cbrt(input int v);
        int s;
        s = 0;
        while (longint'(s + 1) * (s + 1) * (s + 1) <= longint'(v) * 262144) s++;
        return s;
    endfunction : cbrt

    function automatic int isqrt(input int v);
        int s;
        s = 0;
        while ((s + 1) * (s + 1) <= v) s++;
        return s;
    endfunction : isqrt

    // reference: first matching row wins, planar or spatial by mode, 255 below the intensity floor
    task automatic samp(input int r, input int g, input int b);
        int x, y, i, m, row, d2, dp, di, c, best, bc, rad, tol;
        src_u.send(r, g, b);
        coords(r, g, b, x, y, i, m);
        rad = int'(calc_mode[0] ? lab_rad : chroma_rad);
        tol = int'(calc_mode[0] ? light_tol : int_tol);
        row = 255;
        d2 = 0;
        for (int k = 0; k < CMT_ROWS && row == 255 && m >= int'(low_lim); k++) begin
            dp = (x - tx[k]) * (x - tx[k]) + (y - ty[k]) * (y - ty[k]);
            di = i - ti[k];
            if (calc_mode[1] && dp + di * di < int'(sph_rad) * int'(sph_rad)) begin
                row = k;
                d2 = dp + di * di;
            end else if (!calc_mode[1] && dp < rad * rad && di * di <= tol * tol) begin
                row = k;
                d2 = dp;
            end
        end
        c = (row == 255) ? 255 : (group_enable ? grp[row] : row);
        if (trigger_indicator_mode == CMT_TRIGGER_INDICATOR_CONTINUOUS_TRIGGER_MODE) begin
            // launched now, taken one edge later, the pulse stands after the next edge: seen 100 ns on
            q_t.push_back($time + 100);
            q_c.push_back(row);
            q_tr.push_back(0);
        end else if (busy == 0 && c != 0) begin
            q_t.push_back($time + 100);
            q_c.push_back(0);
            q_tr.push_back(1);
            busy = 1;
            n_hit = 0; sx = 0; sy = 0; si = 0; sd = 0;
            foreach (cnt[j]) cnt[j] = 0;
        end else if (busy == 1 && c == 0) begin
            best = 255;
            bc = 0;
            foreach (cnt[j]) if (cnt[j] > bc) begin
                best = j;
                bc = cnt[j];
            end
            q_t.push_back($time + 100);
            q_c.push_back(best);
            q_tr.push_back(1);
            q_at.push_back($time + 100);
            q_a.push_back(n_hit == 0 ? 64'h0 : {16'(sx / n_hit), 16'(sy / n_hit), 16'(si / n_hit),
                16'(sd / n_hit)});
            busy = 0;
            return;
        end
        if (busy == 1 && c != 255) begin
            cnt[c]++;
            n_hit++; sx += x; sy += y; si += i; sd += isqrt(d2);
        end
    endtask : samp

    task automatic hit(input int k);
        if (k < 0) samp(10, 10, 10);
        else samp(br[k] + int'($urandom_range(8)) - 4, bg[k] + int'($urandom_range(8)) - 4,
            bb[k] + int'($urandom_range(8)) - 4);
    endtask : hit

    always @(negedge ref_clk) if (reset_n) begin
        if (trigger_indicator_mode == CMT_TRIGGER_INDICATOR_CONTINUOUS_TRIGGER_MODE) chk(trigger_indicator, 0);
        if (result_valid === 1'b1) begin
            if (q_t.size() == 0) chk(result_valid, 0);
            else begin
                chk($time, q_t.pop_front());
                chk(colour_no, q_c.pop_front());
                chk(trigger_indicator, q_tr.pop_front());
            end
        end
        if (avg_valid === 1'b1) begin
            if (q_a.size() == 0) chk(avg_valid, 0);
            else begin
                chk($time, q_at.pop_front());
                chk(avg, q_a.pop_front());
            end
        end
    end

    initial begin
        #400000;
        bad_count++;
        summarize();
    end

    initial begin
        void'($urandom(32'h7776));
        for (int k = 0; k < CMT_ROWS; k++) begin
            if (k < 5) coords(br[k], bg[k], bb[k], tx[k], ty[k], ti[k], mn);
            else begin
                tx[k] = 4000; ty[k] = 4000; ti[k] = 4000;
            end
            grp[k] = (k == 0 || k == 4) ? 0 : (k == 1 || k == 3) ? 1 : (k == 2) ? 2 : 3;
            taught[k] = '{16'(tx[k]), 16'(ty[k]), 16'(ti[k])};
            taught_group[k] = 5'(grp[k]);
        end
        repeat (12) @(posedge ref_clk);
        reset_n <= 1'b1;
        src_u.idle(2);
        chk(colour_no, CMT_ERR_CODE);
        chk({result_valid, trigger_indicator, avg_valid}, 0);
        // spatial then planar matching, back to back, with error and over-height samples
        repeat (24) hit(int'($urandom_range(5)) - 1);
        samp(0, 0, 0);
        src_u.idle(4);
        @(posedge ref_clk);
        calc_mode <= CMT_XYI_2D;
        repeat (20) hit(int'($urandom_range(5)) - 1);
        samp(2200, 1100, 1100);
        samp(0, 0, 0);
        src_u.idle(4);
        // self trigger on rows: majority, tie, empty interval, non-free row 4
        @(posedge ref_clk);
        calc_mode <= CMT_XYI_3D;
        trigger_indicator_mode <= CMT_TRIGGER_INDICATOR_SELF;
        src_u.idle(2);
        foreach (seq_rows[j]) hit(seq_rows[j]);
        src_u.idle(4);
        // groups: pooled group 1 outranks row 2, row 4 is part of the free state
        @(posedge ref_clk);
        group_enable <= 1'b1;
        src_u.idle(2);
        foreach (seq_grps[j]) hit(seq_grps[j]);
        repeat (30) hit(int'($urandom_range(5)) - 1);
        hit(0);
        src_u.idle(6);
        // Lab-style spatial then planar, continuous, other radii; a high floor turns dim matches into errors
        @(posedge ref_clk);
        calc_mode <= CMT_LAB_3D;
        trigger_indicator_mode <= CMT_TRIGGER_INDICATOR_CONTINUOUS_TRIGGER_MODE;
        lab_rad <= 16'h012C;
        light_tol <= 16'h0028;
        sph_rad <= 16'h00FA;
        low_lim <= 16'h001E;
        src_u.idle(1);
        for (int k = 0; k < 5; k++) begin
            coords(br[k], bg[k], bb[k], tx[k], ty[k], ti[k], mn);
            taught[k] <= '{16'(tx[k]), 16'(ty[k]), 16'(ti[k])};
        end
        src_u.idle(2);
        repeat (20) hit(int'($urandom_range(5)) - 1);
        src_u.idle(2);
        @(posedge ref_clk);
        calc_mode <= CMT_LAB_2D;
        low_lim <= 16'h0514;
        src_u.idle(2);
        repeat (20) hit(int'($urandom_range(5)) - 1);
        src_u.idle(6);
        chk(q_t.size() + q_a.size(), 0);
        summarize();
    end
endmodule : color_match_trigger_logic_tb
